// >>> inc/bcp_map.svh
// offsets, field positions, reset values and codes for the commutation block
`ifndef BCP_MAP_SVH
`define BCP_MAP_SVH

// register byte offsets
`define BCP_OFS_CTRL    4'h0
`define BCP_OFS_STATUS  4'h4
`define BCP_OFS_CYCLES  4'h8

// control register
`define BCP_CTRL_RUN     0
`define BCP_CTRL_RST     1'h1

// status register field positions
`define BCP_ST_CODE_LO   0
`define BCP_ST_VALID     3
`define BCP_ST_UPPER     4
`define BCP_ST_LOWER     5
`define BCP_ST_UV        6
`define BCP_ST_ILIM      7
`define BCP_ST_DIR       8
`define BCP_ST_PHASE     9
`define BCP_ST_ENABLE    10
`define BCP_ST_TOP_LO    11
`define BCP_ST_BOT_LO    14

// sensor codes, written as {a,b,c}
`define BCP_CODE_100     3'h4
`define BCP_CODE_110     3'h6
`define BCP_CODE_111     3'h7
`define BCP_CODE_011     3'h3
`define BCP_CODE_001     3'h1
`define BCP_CODE_000     3'h0
`define BCP_CODE_010     3'h2
`define BCP_CODE_101     3'h5

// phase select vectors, bit 0 is phase a
`define BCP_PH_A         3'h1
`define BCP_PH_B         3'h2
`define BCP_PH_C         3'h4
`define BCP_PH_NONE      3'h0

`define BCP_TOP_OFF      3'h7
`define BCP_BOT_OFF      3'h0
`define BCP_LATCH_RST    1'h0
`define BCP_CYC_RST      16'h0000
`define BCP_SYNC_RST     1'h0

`endif

// >>> inc/bcp_pkg.sv
// types shared by the commutation block
package bcp_pkg;

    typedef enum logic [0:0] {
        BCP_BUS_IDLE = 1'b0,
        BCP_BUS_ACK  = 1'b1
    } bcp_bus_e;

    typedef logic [2:0]  bcp_phase_t;
    typedef logic [15:0] bcp_count_t;

endpackage

// >>> core/bcp_sync2.sv
// two-stage synchroniser for a group of level inputs
`timescale 1ns/10ps
`include "bcp_map.svh"

module bcp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         SYS_CLK,
    input  wire logic         RESET_N,
    input  wire logic [W-1:0] D,
    output logic      [W-1:0] Q
);

    logic [W-1:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            meta_r <= {W{`BCP_SYNC_RST}};
            Q      <= {W{`BCP_SYNC_RST}};
        end else begin
            meta_r <= D;
            Q      <= meta_r;
        end
    end

endmodule // bcp_sync2

// >>> core/bcp_commutator.sv
// six-step commutation decoder, dual-latch pwm gate and avalon registers
`timescale 1ns/10ps
`include "bcp_map.svh"

module bcp_commutator
    import bcp_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        HALL_IN_A,
    input  wire logic        HALL_IN_B,
    input  wire logic        HALL_IN_C,
    input  wire logic        DIRECTION_SELECT,
    input  wire logic        PHASING_SELECT,
    input  wire logic        OUTPUT_ENABLE,
    input  wire logic        OSC_CYCLE_START,
    input  wire logic        PWM_CMP,
    input  wire logic        CURRENT_SENSE,
    input  wire logic        UV_SUPPLY,
    input  wire logic        UV_REFERENCE,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             TOP_DRIVE_A_N,
    output logic             TOP_DRIVE_B_N,
    output logic             TOP_DRIVE_C_N,
    output logic             BOTTOM_DRIVE_A,
    output logic             BOTTOM_DRIVE_B,
    output logic             BOTTOM_DRIVE_C
);

    logic [5:0]  cfg_s;
    logic [4:0]  evt_s;
    logic [2:0]  code_s;
    logic        dir_s;
    logic        phase_s;
    logic        en_s;
    logic        start_s;
    logic        pwm_s;
    logic        ilim_s;
    logic        uv_s;
    logic        start_d_r;
    logic        start_edge;
    logic        upper_r;
    logic        upper_nxt;
    logic        lower_r;
    logic        lower_nxt;
    logic [2:0]  code60;
    logic        code_ok;
    bcp_phase_t  fwd_top;
    bcp_phase_t  fwd_bot;
    bcp_phase_t  top_sel;
    bcp_phase_t  bot_sel;
    logic        run_r;
    logic        gate;
    bcp_phase_t  top_n_r;
    bcp_phase_t  top_n_nxt;
    bcp_phase_t  bot_r;
    bcp_phase_t  bot_nxt;
    bcp_count_t  cyc_r;
    bcp_bus_e    bus_r;
    bcp_bus_e    bus_nxt;
    logic        req;
    logic        wr_take;
    logic        rd_load;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_cycles;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic [31:0] rdata_r;
    logic        wait_r;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    bcp_sync2 #(
        .W (6)
    ) u_sync_cfg (
        .SYS_CLK (SYS_CLK),
        .RESET_N (RESET_N),
        .D       ({HALL_IN_A, HALL_IN_B, HALL_IN_C,
                   DIRECTION_SELECT, PHASING_SELECT, OUTPUT_ENABLE}),
        .Q       (cfg_s)
    );

    bcp_sync2 #(
        .W (5)
    ) u_sync_evt (
        .SYS_CLK (SYS_CLK),
        .RESET_N (RESET_N),
        .D       ({OSC_CYCLE_START, PWM_CMP, CURRENT_SENSE,
                   UV_SUPPLY, UV_REFERENCE}),
        .Q       (evt_s)
    );

    assign code_s  = cfg_s[5:3];
    assign dir_s   = cfg_s[2];
    assign phase_s = cfg_s[1];
    assign en_s    = cfg_s[0];
    assign start_s = evt_s[4];
    assign pwm_s   = evt_s[3];
    assign ilim_s  = evt_s[2];
    assign uv_s    = evt_s[1] | evt_s[0];

    // edge of the ramp discharge, taken from the second stage only
    assign start_edge = start_s & ~start_d_r;

    // overcurrent clears lower latch
    // a comparator already high at cycle start wins, so no runt pulse
    assign upper_nxt = pwm_s  ? 1'b0 : (start_edge ? 1'b1 : upper_r);
    assign lower_nxt = ilim_s ? 1'b0 : (start_edge ? 1'b1 : lower_r);

    // 120 degree codes folded onto the 60 degree table
    // the two tables differ only at two positions, so one decoder serves both
    assign code60 = phase_s ? code_s :
                    (code_s == `BCP_CODE_010) ? `BCP_CODE_111 :
                    (code_s == `BCP_CODE_101) ? `BCP_CODE_000 :
                    (code_s == `BCP_CODE_111) ? `BCP_CODE_010 :
                    (code_s == `BCP_CODE_000) ? `BCP_CODE_101 : code_s;

    assign code_ok = (code60 != `BCP_CODE_101) && (code60 != `BCP_CODE_010);

    assign fwd_top = (code60 == `BCP_CODE_100 || code60 == `BCP_CODE_000) ? `BCP_PH_A :
                     (code60 == `BCP_CODE_110 || code60 == `BCP_CODE_111) ? `BCP_PH_B :
                     (code60 == `BCP_CODE_011 || code60 == `BCP_CODE_001) ? `BCP_PH_C :
                     `BCP_PH_NONE;

    assign fwd_bot = (code60 == `BCP_CODE_100 || code60 == `BCP_CODE_110) ? `BCP_PH_C :
                     (code60 == `BCP_CODE_111 || code60 == `BCP_CODE_011) ? `BCP_PH_A :
                     (code60 == `BCP_CODE_001 || code60 == `BCP_CODE_000) ? `BCP_PH_B :
                     `BCP_PH_NONE;

    assign top_sel = dir_s ? fwd_top : fwd_bot;
    assign bot_sel = dir_s ? fwd_bot : fwd_top;

    assign gate = en_s & run_r & code_ok & ~ilim_s & ~uv_s;

    assign top_n_nxt = gate ? ~top_sel : `BCP_TOP_OFF;

    // both latches must be set, and only a cycle start sets them
    assign bot_nxt = (gate & upper_r & lower_r) ? bot_sel : `BCP_BOT_OFF;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            start_d_r <= `BCP_SYNC_RST;
            upper_r   <= `BCP_LATCH_RST;
            lower_r   <= `BCP_LATCH_RST;
            top_n_r   <= `BCP_TOP_OFF;
            bot_r     <= `BCP_BOT_OFF;
        end else begin
            start_d_r <= start_s;
            upper_r   <= upper_nxt;
            lower_r   <= lower_nxt;
            top_n_r   <= top_n_nxt;
            bot_r     <= bot_nxt;
        end
    end

    // cycle counter wraps; software takes differences
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cyc_r <= `BCP_CYC_RST;
        end else if (start_edge) begin
            cyc_r <= cyc_r + 16'h0001;
        end
    end

    assign TOP_DRIVE_A_N  = top_n_r[0];
    assign TOP_DRIVE_B_N  = top_n_r[1];
    assign TOP_DRIVE_C_N  = top_n_r[2];
    assign BOTTOM_DRIVE_A = bot_r[0];
    assign BOTTOM_DRIVE_B = bot_r[1];
    assign BOTTOM_DRIVE_C = bot_r[2];

    // avalon slave: one wait cycle, answer on the second edge
    assign req        = AVS_READ | AVS_WRITE;
    assign bus_nxt    = (bus_r == BCP_BUS_IDLE && req) ? BCP_BUS_ACK : BCP_BUS_IDLE;
    assign wr_take    = AVS_WRITE & (bus_r == BCP_BUS_ACK);
    assign rd_load    = AVS_READ & (bus_r == BCP_BUS_IDLE);
    assign hit_ctrl   = AVS_ADDRESS == `BCP_OFS_CTRL;
    assign hit_status = AVS_ADDRESS == `BCP_OFS_STATUS;
    assign hit_cycles = AVS_ADDRESS == `BCP_OFS_CYCLES;

    assign status_word = {15'h0000,
                          bot_r,
                          ~top_n_r,
                          en_s,
                          phase_s,
                          dir_s,
                          ilim_s,
                          uv_s,
                          lower_r,
                          upper_r,
                          code_ok,
                          code_s};

    // unmapped offsets read zero and ignore writes
    assign rd_word = hit_ctrl   ? {31'h00000000, run_r} :
                     hit_status ? status_word :
                     hit_cycles ? {16'h0000, cyc_r} : 32'h00000000;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bus_r   <= BCP_BUS_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= 32'h00000000;
            run_r   <= `BCP_CTRL_RST;
        end else begin
            bus_r  <= bus_nxt;
            wait_r <= (bus_nxt != BCP_BUS_ACK);
            if (rd_load) begin
                rdata_r <= rd_word;
            end
            if (wr_take && hit_ctrl && AVS_BYTEENABLE[0]) begin
                run_r <= AVS_WRITEDATA[`BCP_CTRL_RUN];
            end
        end
    end

    assign AVS_READDATA    = rdata_r;
    assign AVS_WAITREQUEST = wait_r;

    a_start_sets: assert property (
        start_edge && !pwm_s && !ilim_s |=> upper_r && lower_r)
        else $error("cycle start did not set both latches");

    a_pwm_clears: assert property (
        pwm_s |=> !upper_r ##1 bot_r == `BCP_BOT_OFF)
        else $error("pwm comparator did not end bottom conduction");

    a_top_no_pwm: assert property (
        pwm_s && gate |=> top_n_r == ~$past(top_sel))
        else $error("top drive followed the pwm comparator");

    a_ilim_kills: assert property (
        ilim_s |=> !lower_r && bot_r == `BCP_BOT_OFF && top_n_r == `BCP_TOP_OFF)
        else $error("overcurrent did not turn drives off");

    a_ilim_holds: assert property (
        !lower_r && !start_edge |=> !lower_r)
        else $error("lower latch re-armed before cycle start");

    a_one_pulse: assert property (
        !upper_r && !start_edge |=> !upper_r ##1 bot_r == `BCP_BOT_OFF)
        else $error("second conduction pulse in one cycle");

    a_map_120: assert property (
        !phase_s && code_s == `BCP_CODE_010 |-> fwd_top == `BCP_PH_B && fwd_bot == `BCP_PH_A)
        else $error("120 degree code 010 decoded wrongly");

    a_map_60: assert property (
        phase_s && code_s == `BCP_CODE_000 |-> fwd_top == `BCP_PH_A && fwd_bot == `BCP_PH_B)
        else $error("60 degree code 000 decoded wrongly");

    a_reverse_swap: assert property (
        gate && !dir_s |=> top_n_r == ~$past(fwd_bot))
        else $error("reverse did not swap phase roles");

    a_invalid_off: assert property (
        !code_ok |=> top_n_r == `BCP_TOP_OFF && bot_r == `BCP_BOT_OFF)
        else $error("invalid code left a drive on");

    a_enable_off: assert property (
        !en_s |=> top_n_r == `BCP_TOP_OFF && bot_r == `BCP_BOT_OFF)
        else $error("enable low left a drive on");

    a_uv_off: assert property (
        uv_s |=> top_n_r == `BCP_TOP_OFF && bot_r == `BCP_BOT_OFF)
        else $error("undervoltage left a drive on");

    a_sense_off: assert property (
        en_s && ilim_s |=> top_n_r == `BCP_TOP_OFF && bot_r == `BCP_BOT_OFF)
        else $error("current sense high left a drive on");

    a_one_top: assert property (
        top_n_r != `BCP_TOP_OFF |-> $onehot(~top_n_r))
        else $error("more than one top drive on");

endmodule // bcp_commutator

// >>> tb/bcp_hall_model.sv
// rotor position sensors and power switch bridge seen by the commutation block
`timescale 1ns/10ps

module bcp_hall_model (
    input  wire logic [2:0] POS,
    input  wire logic       PHASE_60,
    input  wire logic [5:0] DRIVE_ON,
    output logic            HALL_A,
    output logic            HALL_B,
    output logic            HALL_C,
    output logic            SHOOT_THROUGH
);
    // positions 0..5 are rotor steps, 6 and 7 give the codes of a broken sensor wire
    // sensor code per phasing
    localparam logic [23:0] CODES_60  = {3'h2, 3'h5, 3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4};
    localparam logic [23:0] CODES_120 = {3'h0, 3'h7, 3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
    logic [2:0] code;

    assign code = PHASE_60 ? CODES_60[3*POS +: 3] : CODES_120[3*POS +: 3];
    assign {HALL_A, HALL_B, HALL_C} = code;
    // a phase with top and bottom switch both on shorts the supply
    assign SHOOT_THROUGH = |(DRIVE_ON[5:3] & DRIVE_ON[2:0]);
endmodule // bcp_hall_model

// >>> tb/test_bldc_commutation_pwm_logic.sv
// self-checking bench for the commutation and pwm gating block
`timescale 1ns/10ps

module test_bldc_commutation_pwm_logic;
    import bcp_pkg::*;
    logic        SYS_CLK = 1'b0, RESET_N = 1'b0, OUTPUT_ENABLE = 1'b1;
    logic        DIRECTION_SELECT = 1'b0, PHASING_SELECT = 1'b0, OSC_CYCLE_START = 1'b0;
    logic        PWM_CMP = 1'b0, CURRENT_SENSE = 1'b0, UV_SUPPLY = 1'b0, UV_REFERENCE = 1'b0;
    logic        AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [3:0]  AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
    logic        AVS_WAITREQUEST, HALL_IN_A, HALL_IN_B, HALL_IN_C, SHOOT;
    logic        TOP_DRIVE_A_N, TOP_DRIVE_B_N, TOP_DRIVE_C_N;
    logic        BOTTOM_DRIVE_A, BOTTOM_DRIVE_B, BOTTOM_DRIVE_C;
    logic [2:0]  pos = 3'h0;
    logic [5:0]  DRV, e;
    logic [7:0]  r = 8'h4e;
    int          err_count = 0, total_checks = 0, ncyc = 0;

    assign DRV = {~TOP_DRIVE_C_N, ~TOP_DRIVE_B_N, ~TOP_DRIVE_A_N,
                  BOTTOM_DRIVE_C, BOTTOM_DRIVE_B, BOTTOM_DRIVE_A};

    bcp_commutator i_bcp_commutator (.SYS_CLK, .RESET_N, .HALL_IN_A, .HALL_IN_B, .HALL_IN_C,
        .DIRECTION_SELECT, .PHASING_SELECT, .OUTPUT_ENABLE, .OSC_CYCLE_START, .PWM_CMP,
        .CURRENT_SENSE, .UV_SUPPLY, .UV_REFERENCE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .TOP_DRIVE_A_N,
        .TOP_DRIVE_B_N, .TOP_DRIVE_C_N, .BOTTOM_DRIVE_A, .BOTTOM_DRIVE_B, .BOTTOM_DRIVE_C);

    bcp_hall_model i_bcp_hall_model (.POS(pos), .PHASE_60(PHASING_SELECT), .DRIVE_ON(DRV),
        .HALL_A(HALL_IN_A), .HALL_B(HALL_IN_B), .HALL_C(HALL_IN_C), .SHOOT_THROUGH(SHOOT));

    always #2.5 SYS_CLK = ~SYS_CLK;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // {top on, bottom on}, bit 0 of each is phase a
    function automatic logic [5:0] exp_drv(input logic [2:0] c, input logic p60,
                                           input logic fwd);
        logic [5:0] v;
        case (c)
            3'h4: v = 6'h0c;
            3'h6: v = 6'h14;
            3'h3: v = 6'h21;
            3'h1: v = 6'h22;
            3'h7, 3'h2: v = (p60 == (c == 3'h7)) ? 6'h11 : 6'h00;
            default: v = (p60 == (c == 3'h0)) ? 6'h0a : 6'h00;
        endcase
        return fwd ? v : {v[2:0], v[5:3]};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask

    // ramp discharge pulse; count kept for the cycle counter register
    task automatic cyc();
        OSC_CYCLE_START <= 1'b1;
        step(2);
        OSC_CYCLE_START <= 1'b0;
        step(6);
        ncyc++;
    endtask

    task automatic cmp_drv(input logic [5:0] x);
        total_checks++;
        if ({SHOOT, DRV} !== {1'b0, x}) begin
            err_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, {1'b0, x}, {SHOOT, DRV});
        end
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] x);
        total_checks++;
        if (got !== x) begin
            err_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, got);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        step(1);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        // no own limit: a slave that never answers is left to the watchdog
        do begin
            step(1);
        end while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    task automatic summarize();
        $display("errors=%0d checks=%0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        step(20000);
        err_count++;
        summarize();
    end

    initial begin
        step(2);
        RESET_N <= 1'b1;
        step(1);
        cmp_drv(6'h00);
        // every code, both phasings, both directions
        for (int i = 0; i < 32; i++) begin
            pos <= i[2:0];
            PHASING_SELECT <= i[3];
            DIRECTION_SELECT <= i[4];
            step(6);
            cyc();
            e = exp_drv({HALL_IN_A, HALL_IN_B, HALL_IN_C}, i[3], i[4]);
            cmp_drv(e);
            PWM_CMP <= 1'b1;
            step(6);
            cmp_drv({e[5:3], 3'h0});
            PWM_CMP <= 1'b0;
            step(6);
            cmp_drv({e[5:3], 3'h0});
        end
        // each shutdown input pin in mid-conduction, random rotor step
        for (int k = 0; k < 4; k++) begin
            r = lfsr(r);
            pos <= 3'(r % 8'd6);
            PHASING_SELECT <= r[6];
            DIRECTION_SELECT <= r[7];
            step(6);
            cyc();
            e = exp_drv({HALL_IN_A, HALL_IN_B, HALL_IN_C}, r[6], r[7]);
            cmp_drv(e);
            OUTPUT_ENABLE <= (k != 0);
            CURRENT_SENSE <= (k == 1);
            UV_SUPPLY <= (k == 2);
            UV_REFERENCE <= (k == 3);
            step(6);
            cmp_drv(6'h00);
            OUTPUT_ENABLE <= 1'b1;
            CURRENT_SENSE <= 1'b0;
            UV_SUPPLY <= 1'b0;
            UV_REFERENCE <= 1'b0;
            step(6);
            if (k == 1)
                cmp_drv({e[5:3], 3'h0});
            cyc();
            cmp_drv(e);
        end
        av(1'b0, 4'h4, 32'h0);
        cmp_reg(rd & 32'hf, {28'h0, 1'b1, HALL_IN_A, HALL_IN_B, HALL_IN_C});
        av(1'b1, 4'h0, 32'h0);
        step(6);
        cmp_drv(6'h00);
        av(1'b1, 4'h0, 32'h1);
        // low byte lane off: the clearing write must be ignored
        AVS_BYTEENABLE <= 4'he;
        av(1'b1, 4'h0, 32'h0);
        AVS_BYTEENABLE <= 4'hf;
        av(1'b0, 4'h0, 32'h0);
        cmp_reg(rd, 32'h1);
        step(6);
        cyc();
        cmp_drv(e);
        av(1'b0, 4'h8, 32'h0);
        cmp_reg(rd, {16'h0, ncyc[15:0]});
        // counter is read-only, unmapped place reads zero
        av(1'b1, 4'h8, 32'h0);
        av(1'b0, 4'h8, 32'h0);
        cmp_reg(rd, {16'h0, ncyc[15:0]});
        av(1'b0, 4'hc, 32'hffffffff);
        cmp_reg(rd, 32'h0);
        summarize();
    end
endmodule // test_bldc_commutation_pwm_logic
